/* File: src/fglsr_core.sv */
// Flash global lock, software reset and opcode capture on the serial link
`timescale 1ns/1ps
// What this block does
// - global lock opcode sets all lock bits
// - global unlock opcode clears all lock bits
// - opcode-only frame, acted on at select high
// - reset aborts operations, except in continuous read
// - reset clears the volatile state bits except the scheme bit, which keeps its value
// - plain reset pair ignored in quad/EXECUTE_IN_PLACE
// - reset opcodes decoded in single and quad
// - enable-reset then reset in separate frames
// - ignore commands during reset recovery
// - delivered status zero, loaded into the parameter register
// - scheme bit selects lock bits or protect bits
// - busy bit high during internal cycle
module fglsr_core
  import fglsr_pkg::*;
#(
  parameter int          NUM_LOCKS    = 16,
  parameter logic [31:0] RST_CYCLES   = T_RST_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic [3:0]           io_in,
  output logic      [3:0]           io_out,
  output logic      [3:0]           io_oe,
  output logic      [NUM_LOCKS-1:0] lock_bits,
  output logic                      write_protect_by_locks,
  output logic                      write_in_progress
);

  // ****************************************
  // Link domain: opcode shift register
  // ****************************************
  // Select high resets the shifter, so no edge outside a frame is needed.
  logic [7:0] shift_r;
  logic [3:0] bitcnt_r;
  logic       quad_lnk_r;
  logic [7:0] frame_op_r;
  logic       frame_ok_r;
  logic       frame_tgl_r;
  logic       quad_mode_r;

  // Sampled as select falls: sclk is parked between frames, so a
  // synchroniser on it would lag two edges into the first quad frame.
  // Quad mode settles within a few pclk after select rises, well inside
  // the select-high gap, so the level is quiet when select falls.
  always_ff @(negedge cs_n or negedge presetn) begin
    if (!presetn) begin
      quad_lnk_r <= 1'b0;
    end else begin
      quad_lnk_r <= quad_mode_r;
    end
  end

  wire [7:0] shift_nxt = quad_lnk_r ? {shift_r[3:0], io_in} : {shift_r[6:0], io_in[0]};
  wire [3:0] step      = quad_lnk_r ? 4'h4 : 4'h1;

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shift_r  <= 8'h00;
      bitcnt_r <= 4'h0;
    end else begin
      shift_r  <= shift_nxt;
      bitcnt_r <= (bitcnt_r > 4'h8) ? bitcnt_r : bitcnt_r + step;
    end
  end

  // Frame closes on select rising; capture opcode and length there
  always_ff @(posedge cs_n or negedge presetn) begin
    if (!presetn) begin
      frame_op_r  <= 8'h00;
      frame_ok_r  <= 1'b0;
      frame_tgl_r <= 1'b0;
    end else begin
      frame_op_r  <= shift_r;
      frame_ok_r  <= (bitcnt_r == 4'h8);
      frame_tgl_r <= ~frame_tgl_r;
    end
  end

  assign io_out = 4'h0;
  assign io_oe  = 4'h0;

  // ****************************************
  // Crossing into pclk
  // ****************************************
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic [7:0] op_r;
  logic       ok_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= frame_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  wire frame_evt = tgl_s2_r ^ tgl_s3_r;
  // Frame data is stable from the toggle until the next select rise
  assign op_r = frame_op_r;
  assign ok_r = frame_ok_r;

  // ****************************************
  // Command state
  // ****************************************
  typedef enum logic [2:0] {
    FGLSR_IDLE    = 3'b001,
    FGLSR_ARMED   = 3'b010,
    FGLSR_RECOVER = 3'b100
  } fglsr_state_t;

  fglsr_state_t state_r;
  fglsr_state_t state_nxt;
  logic [31:0]  rcnt_r;
  logic [NUM_LOCKS-1:0] locks_r;
  logic wel_r;
  logic sus_r;
  logic xip_r;
  logic pd_r;
  logic busy_r;
  logic scheme_r;
  logic [7:0] param_r;

  wire accept    = frame_evt && ok_r && (state_r != FGLSR_RECOVER);
  wire is_lock   = accept && (op_r == OP_GLOBAL_LOCK);
  wire is_unlock = accept && (op_r == OP_GLOBAL_UNLOCK);
  wire is_en     = accept && (op_r == OP_RESET_ENABLE);
  wire is_rst    = accept && (op_r == OP_RESET);
  wire in_xip    = xip_r;
  wire do_reset  = is_rst && (state_r == FGLSR_ARMED) && !in_xip;
  wire recov_end = (state_r == FGLSR_RECOVER) && (rcnt_r == 32'd0);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FGLSR_IDLE: begin
        if (is_en) begin
          state_nxt = FGLSR_ARMED;
        end
      end
      FGLSR_ARMED: begin
        if (do_reset) begin
          state_nxt = FGLSR_RECOVER;
        end else if (accept && !is_en) begin
          state_nxt = FGLSR_IDLE;
        end
      end
      FGLSR_RECOVER: begin
        if (recov_end) begin
          state_nxt = FGLSR_IDLE;
        end
      end
      default: state_nxt = FGLSR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FGLSR_IDLE;
      rcnt_r  <= 32'd0;
    end else begin
      state_r <= state_nxt;
      rcnt_r  <= do_reset ? RST_CYCLES - 32'd1 : (rcnt_r != 32'd0 ? rcnt_r - 32'd1 : rcnt_r);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  wire wr       = psel && penable && pwrite;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_st   = (paddr == REG_STATUS);
  wire hit_lk   = (paddr == REG_LOCKS);
  wire hit_par  = (paddr == REG_PARAM);
  wire mapped   = hit_ctrl | hit_st | hit_lk | hit_par;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locks_r  <= '0;
      wel_r    <= 1'b0;
      sus_r    <= 1'b0;
      xip_r    <= 1'b0;
      pd_r     <= 1'b0;
      busy_r   <= 1'b0;
      scheme_r <= 1'b0;
      quad_mode_r <= 1'b0;
      param_r  <= STATUS_DELIVERED;
    end else if (do_reset) begin
      // Lock bits are not volatile settings and survive reset
      wel_r    <= 1'b0;
      sus_r    <= 1'b0;
      xip_r    <= 1'b0;
      pd_r     <= 1'b0;
      busy_r   <= 1'b0;
      quad_mode_r <= 1'b0;
      param_r  <= STATUS_DELIVERED;
    end else begin
      if (is_lock) begin
        locks_r <= '1;
      end else if (is_unlock) begin
        locks_r <= '0;
      end
      if (accept && op_r == OP_QUAD_ENTER) begin
        quad_mode_r <= 1'b1;
      end else if (accept && op_r == OP_QUAD_EXIT) begin
        quad_mode_r <= 1'b0;
      end
      if (accept && op_r == OP_WRITE_ENABLE) begin
        wel_r <= 1'b1;
      end else if (accept && op_r == OP_WRITE_DISABLE) begin
        wel_r <= 1'b0;
      end
      if (accept && op_r == OP_SUSPEND && busy_r) begin
        sus_r <= 1'b1;
      end else if (accept && op_r == OP_RESUME && sus_r) begin
        sus_r <= 1'b0;
      end
      if (accept && op_r == OP_POWER_DOWN) begin
        pd_r <= 1'b1;
      end else if (accept && op_r == OP_POWER_UP) begin
        pd_r <= 1'b0;
      end
      if (wr && hit_ctrl) begin
        scheme_r <= pwdata[CTRL_SCHEME];
        busy_r   <= pwdata[CTRL_BUSY] & ~sus_r;
        xip_r    <= pwdata[CTRL_XIP];
      end
      if (wr && hit_par) begin
        param_r <= pwdata[7:0];
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux[CTRL_SCHEME] = scheme_r;
      rd_mux[CTRL_BUSY]   = busy_r;
      rd_mux[CTRL_XIP]    = xip_r;
    end else if (hit_st) begin
      rd_mux[ST_WIP]   = busy_r;
      rd_mux[ST_WEL]   = wel_r;
      rd_mux[ST_SUS]   = sus_r;
      rd_mux[ST_QUAD]  = quad_mode_r;
      rd_mux[ST_XIP]   = xip_r;
      rd_mux[ST_PD]    = pd_r;
      rd_mux[ST_RSTEN] = (state_r == FGLSR_ARMED);
      rd_mux[ST_RECOV] = (state_r == FGLSR_RECOVER);
      rd_mux[ST_PROT]  = ~scheme_r;
    end else if (hit_lk) begin
      rd_mux[NUM_LOCKS-1:0] = locks_r;
    end else if (hit_par) begin
      rd_mux[7:0] = param_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pready  = psel && penable;
  assign pslverr = psel && penable && !mapped;

  assign lock_bits              = locks_r;
  assign write_protect_by_locks = ~scheme_r;
  assign write_in_progress      = busy_r;
endmodule

/* File: common/fglsr_pkg.sv */
// Package: opcodes, register map, field layout and timing for the lock/reset block
package fglsr_pkg;
  // Opcodes
  localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7e;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
  localparam logic [7:0] OP_RESET         = 8'h99;
  localparam logic [7:0] OP_READ_PARAMS   = 8'h5a;
  localparam logic [7:0] OP_QUAD_ENTER    = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT     = 8'hff;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7a;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_POWER_DOWN    = 8'hb9;
  localparam logic [7:0] OP_POWER_UP      = 8'hab;
  localparam logic [7:0] STATUS_DELIVERED = 8'h00;
  localparam logic [7:0] ARRAY_ERASED     = 8'hff;
  localparam logic [7:0] PARAM_TABLE_BYTE = 8'h00;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LOCKS  = 8'h08;
  localparam logic [7:0] REG_PARAM  = 8'h0c;

  // CTRL fields
  localparam int CTRL_SCHEME = 0;
  localparam int CTRL_BUSY   = 1;
  localparam int CTRL_XIP    = 2;
  // STATUS fields
  localparam int ST_WIP    = 0;
  localparam int ST_WEL    = 1;
  localparam int ST_SUS    = 2;
  localparam int ST_QUAD   = 3;
  localparam int ST_XIP    = 4;
  localparam int ST_PD     = 5;
  localparam int ST_RSTEN  = 6;
  localparam int ST_RECOV  = 7;
  localparam int ST_PROT   = 8;

  localparam int OPC_BITS = 8;
  localparam logic [31:0] CLK_MHZ      = 32'd200;
  localparam logic [31:0] T_RST_NS     = 32'd30000;
  localparam logic [31:0] T_RST_CYCLES = (T_RST_NS * CLK_MHZ + 32'd999) / 32'd1000;
endpackage

/* File: verif/fglsr_host.sv */
// Host-side serial controller model that frames opcodes on the link
`timescale 1ns/1ps
module fglsr_host (
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] io_in
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h5;
  end
  // MSB first, 12 ns link clock, clock parked low between frames
  task automatic frame(input logic [15:0] d, input int n, input bit q);
    int i;
    cs_n = 1'b0;
    for (i = 0; i < n; i += (q ? 4 : 1)) begin
      io_in = q ? d[15-i -: 4] : {4{d[15-i]}};
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    // Released lines show the inverse, never a stale level
    io_in = ~io_in;
    #60;
  endtask
endmodule

/* File: verif/fglsr_sva.sv */
// Checker for read-back, lock and busy relations at the block's ports
`timescale 1ns/1ps
module fglsr_sva
  import fglsr_pkg::*;
#(
  parameter int NUM_LOCKS = 16
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 cs_n,
  input wire logic [NUM_LOCKS-1:0] lock_bits,
  input wire logic                 write_protect_by_locks,
  input wire logic                 write_in_progress
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_st  = psel && penable && !pwrite && paddr == REG_STATUS;
  wire ctl_wr = psel && penable && pwrite && paddr == REG_CTRL;
  AST_LOCKS_UNIFORM:
  assert property (lock_bits != '0 |-> &lock_bits) else $error("lock bits not uniform");
  AST_LOCKS_AT_DESELECT:
  assert property (!$stable(lock_bits) |-> cs_n) else $error("lock bits moved in a frame");
  AST_LOCKS_READBACK:
  assert property (psel && penable && !pwrite && paddr == REG_LOCKS
    |-> prdata[NUM_LOCKS-1:0] == $past(lock_bits)) else $error("lock read-back wrong");
  AST_SCHEME_SELECT:
  assert property (ctl_wr |=> write_protect_by_locks == !$past(pwdata[CTRL_SCHEME]))
    else $error("scheme select not applied");
  AST_GOVERN_READBACK:
  assert property (rd_st |-> prdata[ST_PROT] == $past(write_protect_by_locks))
    else $error("govern bit read-back wrong");
  AST_BUSY_SET:
  assert property (ctl_wr && pwdata[CTRL_BUSY] |=> write_in_progress[*2])
    else $error("busy not raised");
  AST_BUSY_READBACK:
  assert property (rd_st |-> prdata[ST_WIP] == $past(write_in_progress))
    else $error("busy read-back wrong");
  AST_DELIVERED:
  assert property ($rose(presetn) |-> lock_bits == '0 && !write_in_progress)
    else $error("state after reset wrong");
endmodule
bind fglsr_core fglsr_sva #(.NUM_LOCKS(NUM_LOCKS)) sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .cs_n(cs_n), .lock_bits(lock_bits),
  .write_protect_by_locks(write_protect_by_locks), .write_in_progress(write_in_progress));

/* File: verif/testbench.sv */
// Self-checking bench for the lock and software reset block
`timescale 1ns/1ps
module testbench;
  import fglsr_pkg::*;
  localparam logic [31:0] W = 32'h1 << ST_WEL;
  localparam logic [31:0] Q = 32'h1 << ST_QUAD;
  localparam logic [31:0] R = 32'h1 << ST_RECOV;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        sclk, cs_n, write_protect_by_locks, write_in_progress;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic [3:0]  io_in, io_out, io_oe;
  logic [15:0] lock_bits;
  integer      seed = 97754;
  int          fails = 0;
  int          cmp_count = 0;
  int          i;
  fglsr_core #(.NUM_LOCKS(16), .RST_CYCLES(32'd200)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .lock_bits(lock_bits),
    .write_protect_by_locks(write_protect_by_locks), .write_in_progress(write_in_progress));
  fglsr_host host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic finish_test;
    $display("counts: mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin fails++; finish_test; end
    r = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic op(input logic [7:0] c, input bit q);
    host.frame({c, 8'h00}, 8, q);
  endtask
  task automatic stm(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r & m, e);
  endtask
  task automatic wait_rec;
    int n;
    n = 0;
    do begin apb(1'b0, REG_STATUS, 32'h0); n++; end while (r[ST_RECOV] !== 1'b0 && n < 500);
    if (n >= 500) begin fails++; finish_test; end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    stm(32'hff, {24'h0, STATUS_DELIVERED});
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'b1, REG_PARAM, v);
      apb(1'b0, REG_PARAM, 32'h0);
      chk(r, v & 32'hff);
      apb(1'b0, 8'h10 | (v[7:0] & 8'hec), 32'h0);
      chk({r[30:0], err}, 32'h1);
    end
    op(OP_GLOBAL_LOCK, 1'b0);
    apb(1'b0, REG_LOCKS, 32'h0); chk(r, 32'hffff);
    host.frame(16'h9800, 4, 1'b0);
    host.frame(16'h9800, 16, 1'b0);
    apb(1'b0, REG_LOCKS, 32'h0); chk(r, 32'hffff);
    op(OP_GLOBAL_UNLOCK, 1'b0);
    apb(1'b0, REG_LOCKS, 32'h0); chk(r, 32'h0);
    op(OP_GLOBAL_LOCK, 1'b0);
    op(OP_WRITE_ENABLE, 1'b0);
    op(OP_RESET, 1'b0);
    stm(W, W);
    op(OP_RESET_ENABLE, 1'b0); op(OP_WRITE_ENABLE, 1'b0); op(OP_RESET, 1'b0);
    stm(W, W);
    stm(32'h1 << ST_WIP, 32'h0);
    op(OP_RESET_ENABLE, 1'b0); op(OP_RESET, 1'b0);
    op(OP_GLOBAL_UNLOCK, 1'b0);
    stm(W | R, R);
    wait_rec;
    apb(1'b0, REG_LOCKS, 32'h0); chk(r, 32'hffff);
    op(OP_QUAD_ENTER, 1'b0); op(OP_WRITE_ENABLE, 1'b1);
    op(OP_RESET_ENABLE, 1'b0); op(OP_RESET, 1'b0);
    stm(Q | W, Q | W);
    host.frame(16'hff00, 8, 1'b0);
    op(OP_RESET_ENABLE, 1'b1); op(OP_RESET, 1'b1); wait_rec;
    stm(32'h7f, 32'h0);
    op(OP_RESET_ENABLE, 1'b0); op(OP_RESET, 1'b0); wait_rec;
    apb(1'b1, REG_CTRL, 32'h1 << CTRL_XIP);
    op(OP_WRITE_ENABLE, 1'b0); op(OP_RESET_ENABLE, 1'b0); op(OP_RESET, 1'b0);
    stm(W, W);
    apb(1'b1, REG_CTRL, 32'h1 << CTRL_SCHEME);
    stm(32'h1 << ST_PROT, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1 << CTRL_BUSY);
    stm(32'h1 << ST_WIP | 32'h1 << ST_PROT, 32'h1 << ST_WIP | 32'h1 << ST_PROT);
    apb(1'b1, REG_CTRL, 32'h0);
    stm(32'h1 << ST_WIP, 32'h0);
    finish_test;
  end
endmodule
